/* File: src/iptr_regs_regs.vh */
/*
  Constants for the indirect pointer unit: register offsets, reset values,
  virtual operand decode and access modes.
  Assumes a single 25 MHz core clock and a synchronous one-cycle data RAM.
*/
// Notes on behaviour
// - There are three independent pointers, each made of a high byte and a low byte register.
// - Only the low four bits of each high byte are used, giving a 12-bit linear pointer.
// - A plain indirect operand accesses RAM at the pointer and leaves the pointer as it is.
// - The indirect operands sit in the special function space but hold no storage.
// - Indirect accesses use the full 12-bit pointer, ignoring bank select and access bit.
// - The post-decrement operand accesses at the pointer, then lowers the pointer by one.
// - The post-increment operand accesses at the pointer, then raises the pointer by one.
// - The pre-increment operand raises the pointer by one, then accesses at the new value.
// - The offset operand accesses at pointer plus signed accumulator, changing neither.
// - A virtual operand cannot itself be the target of an indirect access.
// - Increment and decrement act on the whole pair, carrying from low byte into high.
// - Pointer updates leave every arithmetic status flag untouched.
`ifndef IPTR_REGS_VH
`define IPTR_REGS_VH

// wishbone byte offsets
`define IPTR_OFF_P0_LOW 5'h00
`define IPTR_OFF_P0_HIGH 5'h04
`define IPTR_OFF_P1_LOW 5'h08
`define IPTR_OFF_P1_HIGH 5'h0C
`define IPTR_OFF_P2_LOW 5'h10
`define IPTR_OFF_P2_HIGH 5'h14
`define IPTR_OFF_LAST_ADDR 5'h18
`define IPTR_OFF_STATUS 5'h1C

`define IPTR_PTR_RESET 12'h000
`define IPTR_HIGH_UNUSED 4'h0

// virtual operand window: addr[11:5] selects, addr[4:3] pointer, addr[2:0] mode
`define IPTR_OPND_TAG 7'h7F
`define IPTR_OPND_TAG_POS 5
`define IPTR_OPND_PTR_POS 3

`define IPTR_MODE_PLAIN 3'h0
`define IPTR_MODE_POST_DECREMENT_OPERAND 3'h1
`define IPTR_MODE_POST_INCREMENT_OPERAND 3'h2
`define IPTR_MODE_PRE_INCREMENT_OPERAND 3'h3
`define IPTR_MODE_OFFSET 3'h4

`define IPTR_STEP_ONE 12'h001
`define IPTR_STEP_MINUS_ONE 12'hFFF

`endif

/* File: src/iptr_unit.v */
/*
  Indirect data-memory pointer unit: three 12-bit pointers, virtual operand
  decode, pointer update modes and a one-cycle synchronous RAM port.
  Pointers are also reachable by software over a classic Wishbone slave.
  Assumes the RAM registers its read data on the edge after ram_req.
*/
`default_nettype none
`include "iptr_regs_regs.vh"

module iptr_unit #(
    parameter AW = 12,
    parameter DW = 8
) (
    input wire clk,
    input wire srst,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [4:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // core access port
    input wire core_req,
    input wire core_we,
    input wire [AW-1:0] core_addr,
    input wire [DW-1:0] core_wdata,
    input wire [DW-1:0] core_acc,
    output reg [DW-1:0] core_rdata,
    output reg core_ack,
    output reg core_busy,
    // data ram port
    output reg ram_req,
    output reg ram_we,
    output reg [AW-1:0] ram_addr,
    output reg [DW-1:0] ram_wdata,
    input wire [DW-1:0] ram_rdata
);

    localparam ST_IDLE = 2'd0;
    localparam ST_MEM = 2'd1;
    localparam ST_RD = 2'd2;

    // pointer plus offset, wrapping at the address width
    function [AW-1:0] ptr_add;
        input [AW-1:0] p;
        input [AW-1:0] d;
        begin
            ptr_add = p + d;
        end
    endfunction

    // is the address one of the virtual operands
    function is_opnd;
        input [AW-1:0] a;
        begin
            is_opnd = (a[AW-1:`IPTR_OPND_TAG_POS] == `IPTR_OPND_TAG)
                && (a[`IPTR_OPND_TAG_POS-1:`IPTR_OPND_PTR_POS] != 2'd3)
                && (a[2:0] <= `IPTR_MODE_OFFSET);
        end
    endfunction

    // replace the low byte of a pointer
    function [AW-1:0] with_low;
        input [AW-1:0] p;
        input [DW-1:0] b;
        begin
            with_low = {p[AW-1:DW], b};
        end
    endfunction

    // replace the high byte of a pointer, only its used bits are kept
    function [AW-1:0] with_high;
        input [AW-1:0] p;
        input [AW-DW-1:0] h;
        begin
            with_high = {h, p[DW-1:0]};
        end
    endfunction

    // low byte of a pointer as a bus word
    function [31:0] low_word;
        input [AW-1:0] p;
        begin
            low_word = {24'h000000, p[DW-1:0]};
        end
    endfunction

    // high byte of a pointer as a bus word, unused bits zero
    function [31:0] high_word;
        input [AW-1:0] p;
        begin
            high_word = {24'h000000, `IPTR_HIGH_UNUSED, p[AW-1:DW]};
        end
    endfunction

    reg [AW-1:0] ptr_r [0:2];
    reg [AW-1:0] ptr_nxt [0:2];
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [AW-1:0] last_addr_r;
    reg [AW-1:0] last_addr_nxt;
    reg blocked_r;
    reg blocked_nxt;
    reg ram_req_nxt;
    reg ram_we_nxt;
    reg [AW-1:0] ram_addr_nxt;
    reg [DW-1:0] ram_wdata_nxt;
    reg [DW-1:0] core_rdata_nxt;
    reg core_ack_nxt;
    reg core_busy_nxt;
    reg [31:0] wb_dat_nxt;
    reg wb_ack_nxt;

    wire [1:0] op_ptr;
    wire [2:0] op_mode;
    wire [AW-1:0] cur_ptr;
    wire [AW-1:0] acc_ext;
    wire wb_hit;
    wire wb_wr;
    wire [2:0] wb_idx;
    integer i;

    assign op_ptr = core_addr[`IPTR_OPND_TAG_POS-1:`IPTR_OPND_PTR_POS];
    assign op_mode = core_addr[2:0];
    assign cur_ptr = (op_ptr == 2'd0) ? ptr_r[0] : (op_ptr == 2'd1) ? ptr_r[1] : ptr_r[2];
    // accumulator taken as signed, sign extended to pointer width
    assign acc_ext = {{(AW-DW){core_acc[DW-1]}}, core_acc};
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_hit && wb_we_i && wb_sel_i[0];
    assign wb_idx = wb_adr_i[4:2];

    // core access sequencing and pointer updates
    always @*
    begin
        state_nxt = state_r;
        last_addr_nxt = last_addr_r;
        blocked_nxt = blocked_r;
        ram_req_nxt = 1'b0;
        ram_we_nxt = ram_we;
        ram_addr_nxt = ram_addr;
        ram_wdata_nxt = ram_wdata;
        core_rdata_nxt = core_rdata;
        core_ack_nxt = 1'b0;
        core_busy_nxt = core_busy;
        // each pointer holds unless an operand or software changes it
        ptr_nxt[0] = ptr_r[0];
        ptr_nxt[1] = ptr_r[1];
        ptr_nxt[2] = ptr_r[2];
        case (state_r)
            ST_IDLE:
            begin
                if (core_req)
                begin
                    state_nxt = ST_MEM;
                    core_busy_nxt = 1'b1;
                    ram_we_nxt = core_we;
                    ram_wdata_nxt = core_wdata;
                    ram_addr_nxt = core_addr;
                    // virtual operands hold no storage: redirect through pointer
                    if (is_opnd(core_addr))
                    begin
                        // full pointer, no bank applied
                        case (op_mode)
                            `IPTR_MODE_PLAIN:
                            begin
                                ram_addr_nxt = cur_ptr;
                            end
                            `IPTR_MODE_POST_DECREMENT_OPERAND:
                            begin
                                ram_addr_nxt = cur_ptr;
                                ptr_nxt[op_ptr] = ptr_add(cur_ptr, `IPTR_STEP_MINUS_ONE);
                            end
                            `IPTR_MODE_POST_INCREMENT_OPERAND:
                            begin
                                ram_addr_nxt = cur_ptr;
                                ptr_nxt[op_ptr] = ptr_add(cur_ptr, `IPTR_STEP_ONE);
                            end
                            `IPTR_MODE_PRE_INCREMENT_OPERAND:
                            begin
                                ram_addr_nxt = ptr_add(cur_ptr, `IPTR_STEP_ONE);
                                ptr_nxt[op_ptr] = ptr_add(cur_ptr, `IPTR_STEP_ONE);
                            end
                            `IPTR_MODE_OFFSET:
                            begin
                                ram_addr_nxt = ptr_add(cur_ptr, acc_ext);
                            end
                            default:
                            begin
                                ram_addr_nxt = cur_ptr;
                            end
                        endcase
                    end
                    // a virtual operand as indirect target reaches no storage
                    blocked_nxt = is_opnd(ram_addr_nxt) && is_opnd(core_addr);
                    ram_req_nxt = !blocked_nxt;
                    last_addr_nxt = ram_addr_nxt;
                end
            end
            ST_MEM:
            begin
                state_nxt = ST_RD;
            end
            ST_RD:
            begin
                state_nxt = ST_IDLE;
                core_ack_nxt = 1'b1;
                core_busy_nxt = 1'b0;
                core_rdata_nxt = (blocked_r || ram_we) ? {DW{1'b0}} : ram_rdata;
            end
            default:
            begin
                state_nxt = ST_IDLE;
                core_busy_nxt = 1'b0;
            end
        endcase
        // software write wins over a same-cycle pointer update
        if (wb_wr)
        begin
            // lane 0 only; writes to the address and status words are dropped
            case (wb_idx)
                3'd0: ptr_nxt[0] = with_low(ptr_r[0], wb_dat_i[DW-1:0]);
                3'd1: ptr_nxt[0] = with_high(ptr_r[0], wb_dat_i[AW-DW-1:0]);
                3'd2: ptr_nxt[1] = with_low(ptr_r[1], wb_dat_i[DW-1:0]);
                3'd3: ptr_nxt[1] = with_high(ptr_r[1], wb_dat_i[AW-DW-1:0]);
                3'd4: ptr_nxt[2] = with_low(ptr_r[2], wb_dat_i[DW-1:0]);
                3'd5: ptr_nxt[2] = with_high(ptr_r[2], wb_dat_i[AW-DW-1:0]);
                default:
                begin
                end
            endcase
        end
    end

    // wishbone read mux, unmapped offsets read zero
    always @*
    begin
        wb_ack_nxt = wb_hit;
        wb_dat_nxt = 32'h00000000;
        if (wb_hit && !wb_we_i)
        begin
            // status word: last blocked, busy, not idle from bit 2 down
            case (wb_idx)
                3'd0: wb_dat_nxt = low_word(ptr_r[0]);
                3'd1: wb_dat_nxt = high_word(ptr_r[0]);
                3'd2: wb_dat_nxt = low_word(ptr_r[1]);
                3'd3: wb_dat_nxt = high_word(ptr_r[1]);
                3'd4: wb_dat_nxt = low_word(ptr_r[2]);
                3'd5: wb_dat_nxt = high_word(ptr_r[2]);
                3'd6: wb_dat_nxt = {20'h00000, last_addr_r};
                3'd7: wb_dat_nxt = {29'h0000000, blocked_r, core_busy, (state_r != ST_IDLE)};
                default: wb_dat_nxt = 32'h00000000;
            endcase
        end
    end

    // no status flags exist here: pointer updates touch only the pointers
    always @(posedge clk)
    begin
        if (srst)
        begin
            for (i = 0; i < 3; i = i + 1)
            begin
                ptr_r[i] <= `IPTR_PTR_RESET;
            end
            state_r <= ST_IDLE;
            last_addr_r <= `IPTR_PTR_RESET;
            blocked_r <= 1'b0;
            ram_req <= 1'b0;
            ram_we <= 1'b0;
            ram_addr <= {AW{1'b0}};
            ram_wdata <= {DW{1'b0}};
            core_rdata <= {DW{1'b0}};
            core_ack <= 1'b0;
            core_busy <= 1'b0;
            wb_dat_o <= 32'h00000000;
            wb_ack_o <= 1'b0;
        end
        else
        begin
            for (i = 0; i < 3; i = i + 1)
            begin
                ptr_r[i] <= ptr_nxt[i];
            end
            state_r <= state_nxt;
            last_addr_r <= last_addr_nxt;
            blocked_r <= blocked_nxt;
            ram_req <= ram_req_nxt;
            ram_we <= ram_we_nxt;
            ram_addr <= ram_addr_nxt;
            ram_wdata <= ram_wdata_nxt;
            core_rdata <= core_rdata_nxt;
            core_ack <= core_ack_nxt;
            core_busy <= core_busy_nxt;
            wb_dat_o <= wb_dat_nxt;
            wb_ack_o <= wb_ack_nxt;
        end
    end

endmodule // iptr_unit
`default_nettype wire

/* File: tb/iptr_ram_model.sv */
/* synchronous data ram behind the pointer unit
   assumes read data is wanted only in the cycle after a request */
`default_nettype none
module iptr_ram_model (
    input wire logic clk,
    input wire logic ram_req,
    input wire logic ram_we,
    input wire logic [11:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    output var logic [7:0] ram_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:4095];
    initial ram_rdata = 8'h00;
    always @(posedge clk)
    begin
        if (ram_req && ram_we)
            mem[ram_addr] <= ram_wdata;
        // stale data is inverted so late sampling shows up
        ram_rdata <= ram_req ? mem[ram_addr] : ~ram_rdata;
    end
endmodule // iptr_ram_model
`default_nettype wire

/* File: tb/iptr_unit_properties.sv */
/* port checker for iptr_unit, bound to every instance
   assumes clk rising edge and srst synchronous active high */
`default_nettype none
module iptr_unit_props (
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic core_req,
    input wire logic core_we,
    input wire logic [11:0] core_addr,
    input wire logic [7:0] core_wdata,
    input wire logic [7:0] core_rdata,
    input wire logic core_ack,
    input wire logic core_busy,
    input wire logic ram_req,
    input wire logic ram_we,
    input wire logic [11:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    input wire logic [7:0] ram_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    wire take = core_req && !core_busy;
    wb_ack_lat_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("wishbone ack late");
    wb_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("wishbone ack too long");
    high_zero_a: assert property (wb_ack_o && $past(wb_adr_i[2]) && !$past(wb_we_i)
        |-> wb_dat_o[31:4] == 28'h0) else $error("unused high bits set");
    core_ack_lat_a: assert property (take |-> ##3 core_ack)
        else $error("core ack late");
    busy_span_a: assert property (take |=> core_busy [*2] ##1 !core_busy)
        else $error("busy span wrong");
    ram_pulse_a: assert property (ram_req |=> !ram_req)
        else $error("ram request too long");
    ram_dir_a: assert property (ram_req |-> ram_we == $past(core_we)
        && (!ram_we || ram_wdata == $past(core_wdata))) else $error("ram write wrong");
    direct_addr_a: assert property (ram_req && $past(core_addr[11:5]) != 7'h7F
        |-> ram_addr == $past(core_addr)) else $error("direct address changed");
    read_data_a: assert property (core_ack && $past(ram_req, 2) && !$past(ram_we, 2)
        |-> core_rdata == $past(ram_rdata)) else $error("read data lost");
endmodule // iptr_unit_props
bind iptr_unit iptr_unit_props u_props (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .core_req, .core_we, .core_addr, .core_wdata,
    .core_rdata, .core_ack, .core_busy, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_rdata);
`default_nettype wire

/* File: tb/tb.sv */
/* self-checking bench for iptr_unit with a ram model
   assumes the unit's wishbone map and core port timing */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, creq = 1'b0, cwe = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] dat = 32'h0, wq;
    logic [11:0] caddr = 12'h000;
    logic [7:0] cwd = 8'h00, acc = 8'h00, rq;
    wire [31:0] dat_o;
    wire ack, cack, busy, rreq, rwe;
    wire [11:0] raddr;
    wire [7:0] crd, rwd, ramq;
    integer error_cnt = 0, check_count = 0;
    always #20 clk = ~clk;
    iptr_unit DUT (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .core_req(creq), .core_we(cwe), .core_addr(caddr), .core_wdata(cwd), .core_acc(acc),
        .core_rdata(crd), .core_ack(cack), .core_busy(busy), .ram_req(rreq), .ram_we(rwe),
        .ram_addr(raddr), .ram_wdata(rwd), .ram_rdata(ramq));
    iptr_ram_model u_ram (.clk(clk), .ram_req(rreq), .ram_we(rwe), .ram_addr(raddr),
        .ram_wdata(rwd), .ram_rdata(ramq));
    task summarize;
        if (error_cnt == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input [31:0] s, input [31:0] e);
        check_count = check_count + 1;
        if (s !== e)
        begin
            error_cnt = error_cnt + 1;
            $display("BAD %0t got %h want %h", $time, s, e);
        end
    endtask
    task give_up;
        error_cnt = error_cnt + 1;
        $display("BAD %0t timeout", $time);
        summarize;
    endtask
    task wb(input w, input [4:0] a, input [31:0] d);
        integer n;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        n = 0;
        do begin @(posedge clk); n = n + 1; end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) give_up;
        wq = dat_o;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task core(input [11:0] a, input w, input [7:0] d, input [7:0] c);
        integer n;
        @(posedge clk);
        creq <= 1'b1; caddr <= a; cwe <= w; cwd <= d; acc <= c;
        @(posedge clk);
        creq <= 1'b0;
        n = 0;
        do begin @(posedge clk); n = n + 1; end while (cack !== 1'b1 && n < 8);
        if (cack !== 1'b1) give_up;
        rq = crd;
    endtask
    task ptr_is(input [4:0] lo, input [11:0] e);
        wb(1'b0, lo, 32'h0);
        chk(wq, {24'h0, e[7:0]});
        wb(1'b0, lo + 5'h04, 32'h0);
        chk(wq, {28'h0, e[11:8]});
    endtask
    task set_ptr(input [4:0] lo, input [11:0] v);
        wb(1'b1, lo, {24'h0, v[7:0]});
        wb(1'b1, lo + 5'h04, {24'h0, 4'hF, v[11:8]});
    endtask
    task s_reset;
        ptr_is(5'h00, 12'h000);
        ptr_is(5'h08, 12'h000);
        ptr_is(5'h10, 12'h000);
    endtask
    task s_modes;
        core(12'h0FF, 1'b1, 8'hA5, 8'h00);
        core(12'h100, 1'b1, 8'h5A, 8'h00);
        core(12'h101, 1'b1, 8'h3C, 8'h00);
        set_ptr(5'h08, 12'h0FF);
        core(12'hFEA, 1'b0, 8'h00, 8'h00); chk(rq, 8'hA5);
        ptr_is(5'h08, 12'h100);
        core(12'hFE8, 1'b0, 8'h00, 8'h00); chk(rq, 8'h5A);
        ptr_is(5'h08, 12'h100);
        core(12'hFEB, 1'b0, 8'h00, 8'h00); chk(rq, 8'h3C);
        ptr_is(5'h08, 12'h101);
        core(12'hFE9, 1'b0, 8'h00, 8'h00); chk(rq, 8'h3C);
        ptr_is(5'h08, 12'h100);
        core(12'hFEC, 1'b0, 8'h00, 8'hFF); chk(rq, 8'hA5);
        core(12'hFEC, 1'b0, 8'h00, 8'h01); chk(rq, 8'h3C);
        ptr_is(5'h08, 12'h100);
        wb(1'b0, 5'h1C, 32'h0); chk(wq, 32'h0);
    endtask
    task s_wrap;
        core(12'hFFF, 1'b1, 8'h96, 8'h00);
        set_ptr(5'h00, 12'hFFF);
        core(12'hFE2, 1'b0, 8'h00, 8'h00); chk(rq, 8'h96);
        ptr_is(5'h00, 12'h000);
        core(12'hFE0, 1'b1, 8'hC3, 8'h00);
        core(12'h000, 1'b0, 8'h00, 8'h00); chk(rq, 8'hC3);
        core(12'hFE1, 1'b0, 8'h00, 8'h00); chk(rq, 8'hC3);
        ptr_is(5'h00, 12'hFFF);
    endtask
    task s_block;
        set_ptr(5'h10, 12'hFE8);
        core(12'hFF0, 1'b0, 8'h00, 8'h00); chk(rq, 8'h00);
        wb(1'b0, 5'h1C, 32'h0); chk(wq[2], 1'b1);
    endtask
    task s_rerst;
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        s_reset;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        s_reset;
        s_modes;
        s_wrap;
        s_block;
        s_rerst;
        summarize;
    end
endmodule // tb
`default_nettype wire
